/* srp_cfg.svh */
// Constants for the serial port reset and pin control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
// Control reset values
`define SRP_RST_ENABLE 1'b0
`define SRP_RST_MASTER 1'b1
`define SRP_RST_CLOCK_PHASE_SELECT 1'b1
`define SRP_RST_WIRED_OR 1'b0
`define SRP_RST_MFEN 1'b0
`define SRP_RST_IE 1'b0
// Transmit-empty flag is set out of reset
`define SRP_RST_TX_EMPTY 1'b1
// Bits per byte, master half period of the serial clock and bus clock period
`define SRP_BITS 8
`define SRP_HALF_NS 100
`define SRP_CLK_NS 25
`endif

/* srp_pkg.sv */
// Types for the serial port reset and pin control block.
// Assumes srp_cfg.svh sits in the same folder.
`include "srp_cfg.svh"
package srp_pkg;
    // Master engine states
    typedef enum logic [1:0] {
        SRP_IDLE = 2'b01,
        SRP_RUN = 2'b10
    } srp_state_t;
endpackage : srp_pkg

/* srp_spi_port.sv */
// Serial port core: full and partial reset, wait and halt behaviour,
// master engine, slave link engine and ownership of the four shared pins.
// Assumes strobes come from logic on clk; pins and the link clock are foreign.
`timescale 1ns/1ps
`default_nettype none
`include "srp_cfg.svh"
// Contract
// RULE1: System reset returns every control bit, flag, shifter and counter to initial.
// RULE2: Enable low: set transmit empty, abort, clear shifter and counter, pins to GPIO.
// RULE3: Enable low keeps control bits and receive-full, overrun, mode-fault flags.
// RULE4: Master mode fault with detection on clears the enable bit itself.
// RULE5: In wait mode port runs, accesses ignored, enabled flags request wakeup.
// RULE6: Protected halt: accesses never change flags; armed clears finish after halt.
// RULE7: Halt with clear enable one: clears work and stay cleared.
// RULE8: Protected halt: data writes ignored, no transfer, no load.
// RULE9: Wired-OR select makes master data-out open drain, pulling low only.
// RULE10: Slave data-out driven only as slave with slave-select low; else floats.
// RULE11: Enabled port owns direction of data-in, data-out and serial clock pins.
// RULE12: Master drives serial clock, slave takes it; eight clocks move one byte.
// RULE13: Master shifts out and in during the same clock cycles.
// RULE14: External master toggles slave-select between bytes for phase zero.
// RULE15: Slave with select high ignores serial clock edges and floats data-out.
// RULE16: As slave, select is always an input; detection only gates the fault flag.
// RULE17: Master without detection leaves select as GPIO; with it, input only.
// RULE18: Select pin level is always readable through the port data path.
// RULE19: Phase zero slave transfer starts on select fall, ends after eighth bit.
// RULE20: Halt and halt-clear-enable are inputs sampled on the bus clock.
module srp_spi_port #(
    parameter int HALF_CYC = (`SRP_HALF_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic ctrl_wr,
    input wire logic ctrl_enable,
    input wire logic ctrl_master,
    input wire logic ctrl_clock_phase_select,
    input wire logic ctrl_wired_or,
    input wire logic ctrl_mfen,
    input wire logic ctrl_rx_ie,
    input wire logic ctrl_tx_ie,
    input wire logic ctrl_err_ie,
    input wire logic status_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic wait_mode,
    input wire logic halt,
    input wire logic halt_clear_en,
    input wire logic [3:0] gpio_ddr,
    input wire logic [3:0] gpio_out,
    input wire logic miso_in,
    input wire logic mosi_in,
    input wire logic sck_in,
    input wire logic ss_n_in,
    output logic miso_out,
    output logic miso_oe_n,
    output logic mosi_out,
    output logic mosi_oe_n,
    output logic sck_out,
    output logic sck_oe_n,
    output logic ss_n_out,
    output logic ss_n_oe_n,
    output logic [3:0] pin_level,
    output logic module_enable_bit,
    output logic master_select_bit,
    output logic transmit_empty_flag,
    output logic receive_full_flag,
    output logic overrun_flag,
    output logic mode_fault_flag,
    output logic [7:0] rx_data_reg,
    output logic wake_req
);
    import srp_pkg::*;

    // Divider is eight bits wide, so the half period must fit in it
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_half_cyc_bad
        $error("HALF_CYC out of range");
    end

    logic clock_phase_select_reg, wom_reg, mfen_reg, rx_ie_reg, tx_ie_reg, err_ie_reg;
    logic [3:0] p1_reg, p2_reg;
    logic acc_ok, clr_ok, ss_lo, slave_sel, fault_m, fault_s;
    logic rx_arm_reg, mf_arm_reg, ss_prev_reg, sl_active_reg;
    logic [7:0] tx_data_reg, m_sh_reg, rx_byte;
    logic m_in_reg, m_sck_reg, m_done;
    logic [7:0] div_reg;
    logic [3:0] m_cnt_reg;
    srp_state_t st_reg;
    logic [2:0] dn_sync_reg, go_sync_reg;
    logic link_rst, l_go_reg, l_dn_tgl_reg;
    logic [7:0] l_sh_reg, l_hold_reg;
    logic [3:0] l_cnt_reg;
    logic s_done, s_start;

    // Two-flop sync of foreign pins: order miso, mosi, sck, ss
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p1_reg <= 4'hF;
            p2_reg <= 4'hF;
        end else if (ce) begin
            p1_reg <= {ss_n_in, sck_in, mosi_in, miso_in};
            p2_reg <= p1_reg;
        end
    end
    assign pin_level = p2_reg; // [RULE18]
    assign ss_lo = ~p2_reg[3];

    // Accesses blocked in wait; halt state taken straight from system logic
    assign acc_ok = ~wait_mode; // [RULE5] [RULE20]
    assign clr_ok = ~halt | halt_clear_en; // [RULE6] [RULE7]
    assign slave_sel = module_enable_bit & ~master_select_bit;
    assign fault_m = module_enable_bit & master_select_bit & mfen_reg & ss_lo;
    assign fault_s = slave_sel & mfen_reg & ~ss_lo & ss_prev_reg & sl_active_reg;

    // Control bits: only system reset or a control write clears them; fault drops enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin // [RULE1]
            module_enable_bit <= `SRP_RST_ENABLE;
            master_select_bit <= `SRP_RST_MASTER;
            clock_phase_select_reg <= `SRP_RST_CLOCK_PHASE_SELECT;
            wom_reg <= `SRP_RST_WIRED_OR;
            mfen_reg <= `SRP_RST_MFEN;
            rx_ie_reg <= `SRP_RST_IE;
            tx_ie_reg <= `SRP_RST_IE;
            err_ie_reg <= `SRP_RST_IE;
        end else if (ce) begin
            if (fault_m) begin
                module_enable_bit <= 1'b0; // [RULE4]
            end else if (ctrl_wr && acc_ok) begin
                module_enable_bit <= ctrl_enable;
            end
            if (ctrl_wr && acc_ok) begin // [RULE3]
                master_select_bit <= ctrl_master;
                clock_phase_select_reg <= ctrl_clock_phase_select;
                wom_reg <= ctrl_wired_or;
                mfen_reg <= ctrl_mfen;
                rx_ie_reg <= ctrl_rx_ie;
                tx_ie_reg <= ctrl_tx_ie;
                err_ie_reg <= ctrl_err_ie;
            end
        end
    end

    // Receive flags: two-step clear, armed by status read, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            receive_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            rx_arm_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else if (ce) begin
            if (acc_ok && clr_ok && status_rd && (receive_full_flag || overrun_flag)) begin
                rx_arm_reg <= 1'b1;
            end else if (acc_ok && clr_ok && data_rd) begin
                rx_arm_reg <= 1'b0;
            end
            if (acc_ok && clr_ok && data_rd && rx_arm_reg) begin // [RULE6] [RULE7]
                receive_full_flag <= 1'b0;
                overrun_flag <= 1'b0;
            end
            if (m_done || s_done) begin
                if (receive_full_flag && !(acc_ok && clr_ok && data_rd && rx_arm_reg)) begin
                    overrun_flag <= 1'b1; // Late byte is dropped
                end else begin
                    receive_full_flag <= 1'b1;
                    rx_data_reg <= rx_byte;
                end
            end
        end
    end
    assign rx_byte = m_done ? {m_sh_reg[6:0], m_in_reg} : l_hold_reg;

    // Mode fault flag: armed by status read, cleared by control write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_fault_flag <= 1'b0;
            mf_arm_reg <= 1'b0;
        end else if (ce) begin
            if (acc_ok && clr_ok && status_rd && mode_fault_flag) begin
                mf_arm_reg <= 1'b1;
            end else if (acc_ok && clr_ok && ctrl_wr) begin
                mf_arm_reg <= 1'b0;
            end
            if (fault_m || fault_s) begin
                mode_fault_flag <= 1'b1; // [RULE16] [RULE17]
            end else if (acc_ok && clr_ok && ctrl_wr && mf_arm_reg) begin
                mode_fault_flag <= 1'b0;
            end
        end
    end

    // Transmit register and empty flag; protected halt drops the write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transmit_empty_flag <= `SRP_RST_TX_EMPTY;
            tx_data_reg <= 8'h00;
        end else if (ce) begin
            if (!module_enable_bit) begin
                transmit_empty_flag <= 1'b1; // [RULE2]
            end else if ((st_reg == SRP_IDLE && master_select_bit && !transmit_empty_flag) || s_start) begin
                transmit_empty_flag <= 1'b1;
            end else if (data_wr && acc_ok && clr_ok) begin // [RULE8]
                transmit_empty_flag <= 1'b0;
                tx_data_reg <= data_wdata;
            end
        end
    end

    // Master engine: divider makes the serial clock, shift in and out together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= SRP_IDLE;
            m_sh_reg <= 8'h00;
            m_in_reg <= 1'b0;
            m_sck_reg <= 1'b0;
            div_reg <= 8'h00;
            m_cnt_reg <= 4'h0;
        end else if (ce) begin
            if (!module_enable_bit || !master_select_bit) begin // [RULE2]
                st_reg <= SRP_IDLE;
                m_sh_reg <= 8'h00;
                m_sck_reg <= 1'b0;
                div_reg <= 8'h00;
                m_cnt_reg <= 4'h0;
            end else begin
                case (st_reg)
                    SRP_IDLE: begin
                        if (!transmit_empty_flag) begin
                            st_reg <= SRP_RUN;
                            m_sh_reg <= tx_data_reg;
                            m_cnt_reg <= 4'h0;
                            div_reg <= 8'h00;
                        end
                    end
                    SRP_RUN: begin
                        if (div_reg == 8'(HALF_CYC - 1)) begin
                            div_reg <= 8'h00;
                            m_sck_reg <= ~m_sck_reg; // [RULE12]
                            if (!m_sck_reg) begin
                                m_in_reg <= p2_reg[0]; // [RULE13]
                            end else if (m_cnt_reg == 4'(`SRP_BITS - 1)) begin
                                st_reg <= SRP_IDLE;
                                m_cnt_reg <= 4'h0;
                            end else begin
                                m_sh_reg <= {m_sh_reg[6:0], m_in_reg}; // [RULE13]
                                m_cnt_reg <= m_cnt_reg + 4'h1;
                            end
                        end else begin
                            div_reg <= div_reg + 8'h01;
                        end
                    end
                    default: st_reg <= SRP_IDLE;
                endcase
            end
        end
    end
    assign m_done = ce && st_reg == SRP_RUN && m_sck_reg && div_reg == 8'(HALF_CYC - 1)
        && m_cnt_reg == 4'(`SRP_BITS - 1);

    // Slave link domain: held in reset while disabled or deselected
    assign link_rst = rst | ~module_enable_bit | master_select_bit | ss_n_in; // [RULE15]
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            l_sh_reg <= 8'h00;
            l_cnt_reg <= 4'h0;
            l_go_reg <= 1'b0;
        end else begin
            l_go_reg <= 1'b1;
            l_sh_reg <= (l_cnt_reg == 4'h0) ? {tx_data_reg[6:0], mosi_in} : {l_sh_reg[6:0], mosi_in};
            l_cnt_reg <= (l_cnt_reg == 4'(`SRP_BITS - 1)) ? 4'h0 : l_cnt_reg + 4'h1; // [RULE12]
        end
    end

    // Finished byte held and announced by toggle; survives deselect
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l_hold_reg <= 8'h00;
            l_dn_tgl_reg <= 1'b0;
        end else if (!link_rst && l_cnt_reg == 4'(`SRP_BITS - 1)) begin
            l_hold_reg <= {l_sh_reg[6:0], mosi_in};
            l_dn_tgl_reg <= ~l_dn_tgl_reg; // [RULE19]
        end
    end

    // Bring link events into clk; only the second flop onward is looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dn_sync_reg <= 3'h0;
            go_sync_reg <= 3'h0;
        end else if (ce) begin
            dn_sync_reg <= {dn_sync_reg[1:0], l_dn_tgl_reg};
            go_sync_reg <= {go_sync_reg[1:0], l_go_reg};
        end
    end
    assign s_done = ce && slave_sel && (dn_sync_reg[2] ^ dn_sync_reg[1]);
    assign s_start = ce && slave_sel && go_sync_reg[1] && !go_sync_reg[2];

    // Slave transfer window for fault detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_prev_reg <= 1'b0;
            sl_active_reg <= 1'b0;
        end else if (ce) begin
            ss_prev_reg <= ss_lo;
            if (!slave_sel || !ss_lo || s_done) begin
                sl_active_reg <= 1'b0;
            end else if ((!clock_phase_select_reg && !ss_prev_reg) || s_start) begin
                sl_active_reg <= 1'b1; // [RULE19]
            end
        end
    end

    // Pin ownership; output enables are active low
    always_comb begin
        {ss_n_out, sck_out, mosi_out, miso_out} = gpio_out;
        {ss_n_oe_n, sck_oe_n, mosi_oe_n, miso_oe_n} = ~gpio_ddr; // [RULE2]
        if (module_enable_bit && master_select_bit) begin // [RULE11]
            sck_out = m_sck_reg;
            sck_oe_n = 1'b0; // [RULE12]
            mosi_out = m_sh_reg[7];
            mosi_oe_n = wom_reg & m_sh_reg[7]; // [RULE9]
            miso_oe_n = 1'b1;
            if (mfen_reg) begin
                ss_n_oe_n = 1'b1; // [RULE17]
            end
        end else if (module_enable_bit) begin
            sck_oe_n = 1'b1;
            mosi_oe_n = 1'b1;
            ss_n_oe_n = 1'b1; // [RULE16]
            miso_out = (l_cnt_reg == 4'h0) ? tx_data_reg[7] : l_sh_reg[7];
            miso_oe_n = ss_n_in; // [RULE10] [RULE15]
        end
    end

    // Wake request from any enabled flag; transmit empty counts only while module enable is set
    assign wake_req = (rx_ie_reg & receive_full_flag) | (err_ie_reg & (overrun_flag | mode_fault_flag))
        | (tx_ie_reg & module_enable_bit & transmit_empty_flag); // [RULE5]

    AST_PARTIAL_EMPTY: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        ce && !module_enable_bit |=> transmit_empty_flag)
        else $error("empty flag not set while disabled");
    AST_FAULT_DROPS_EN: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        fault_m |=> !module_enable_bit && mode_fault_flag)
        else $error("master fault kept enable");
    AST_HALT_KEEPS_RX: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        halt && !halt_clear_en && !m_done && !s_done |=> $stable(receive_full_flag) && $stable(overrun_flag))
        else $error("flag changed in protected halt");
    AST_HALT_NO_WRITE: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        ce && halt && !halt_clear_en && data_wr |=> $stable(tx_data_reg))
        else $error("data write took effect in halt");
    AST_DISABLED_KEEPS: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        ce && !module_enable_bit && !ctrl_wr |=> $stable(master_select_bit) && $stable(mfen_reg))
        else $error("control changed by partial reset");
    AST_WOM_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        module_enable_bit && master_select_bit && wom_reg |-> mosi_oe_n || !mosi_out)
        else $error("open drain drove high");
    AST_MISO_FLOAT: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        module_enable_bit && (master_select_bit || ss_n_in) |-> miso_oe_n)
        else $error("slave data out driven");
    AST_MASTER_BYTE: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        m_done |-> m_cnt_reg == 4'(`SRP_BITS - 1) && st_reg == SRP_RUN ##1 st_reg == SRP_IDLE || !ce)
        else $error("master byte not eight bits");
    AST_SS_INPUT: assert property (@(posedge clk) disable iff (rst) // [RULE16]
        slave_sel |-> ss_n_oe_n)
        else $error("select driven as slave");
endmodule : srp_spi_port
`default_nettype wire

/* srp_far_dev.sv */
// Far-side serial device: slave to the port's master, or master on the link clock.
// Assumes the bench resolves the shared lines and feeds them back here.
`timescale 1ns/1ps
`default_nettype none
module srp_far_dev (
    input wire logic as_slave,
    input wire logic [7:0] ld,
    input wire logic sck_line,
    input wire logic mosi_line,
    input wire logic miso_line,
    output var logic p_miso,
    output var logic p_mosi,
    output var logic p_sck,
    output var logic p_ss_n,
    output var logic [7:0] rx_got,
    output var logic [7:0] m_rx
);
    localparam int HALF = 24;
    logic [7:0] sh = 8'h00;
    // Released lines rest at the pull-up level; the clock stands low outside frames
    initial begin
        p_mosi = 1'h1;
        p_sck = 1'h0;
        p_ss_n = 1'h1;
        rx_got = 8'h00;
        m_rx = 8'h00;
    end
    assign p_miso = as_slave ? sh[7] : 1'h1;
    // Slave side: load on select, sample on rise, shift on fall
    always @(posedge as_slave) sh = ld;
    always @(posedge sck_line) if (as_slave) rx_got = {rx_got[6:0], mosi_line};
    always @(negedge sck_line) if (as_slave) sh = {sh[6:0], 1'h0};
    // Master side, phase zero: a short count aborts the byte mid-way
    task automatic send(input logic [7:0] b, input int n);
        p_ss_n = 1'h0;
        #(HALF);
        for (int i = 0; i < n; i++) begin
            p_mosi = b[7 - i];
            #(HALF);
            p_sck = 1'h1;
            m_rx = {m_rx[6:0], miso_line};
            #(HALF);
            p_sck = 1'h0;
        end
        #(HALF);
        p_ss_n = 1'h1;
        p_mosi = 1'h1;
        #(HALF * 2);
    endtask : send
endmodule : srp_far_dev
`default_nettype wire

/* test_spi_reset_and_pin_control.sv */
// Bench for the serial port reset and pin control block.
// Assumes srp_spi_port and srp_far_dev are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_spi_reset_and_pin_control;
    import srp_pkg::*;
    logic clk = 1'h0;
    logic rst, ce, ctrl_wr, en, ms, clock_phase_select, wo, mf, rie, status_rd, data_rd, data_wr;
    logic wait_mode, halt, hce, as_slave, ss_low, wo_bad;
    logic [7:0] wdata, ld, rxd, rx_got, m_rx;
    logic [3:0] ddr, gout, pin_level;
    logic miso_out, miso_oe_n, mosi_out, mosi_oe_n, sck_out, sck_oe_n, ss_n_out, ss_n_oe_n;
    logic men, msel, txe, rxf, ovr, mfl, wake, p_miso, p_mosi, p_sck, p_ss_n;
    wire miso_line, mosi_line, sck_line, ss_line;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    // Released data and select lines sit at the pull-up; the clock line idles low
    assign miso_line = !miso_oe_n ? miso_out : p_miso;
    assign mosi_line = !mosi_oe_n ? mosi_out : p_mosi;
    assign sck_line = !sck_oe_n ? sck_out : p_sck;
    assign ss_line = !ss_n_oe_n ? ss_n_out : (ss_low ? 1'h0 : p_ss_n);
    srp_spi_port DUT (.clk(clk), .rst(rst), .ce(ce), .link_clk(p_sck), .ctrl_wr(ctrl_wr),
        .ctrl_enable(en), .ctrl_master(ms), .ctrl_clock_phase_select(clock_phase_select), .ctrl_wired_or(wo), .ctrl_mfen(mf),
        .ctrl_rx_ie(rie), .ctrl_tx_ie(1'h0), .ctrl_err_ie(rie), .status_rd(status_rd), .data_rd(data_rd),
        .data_wr(data_wr), .data_wdata(wdata), .wait_mode(wait_mode), .halt(halt), .halt_clear_en(hce),
        .gpio_ddr(ddr), .gpio_out(gout), .miso_in(miso_line), .mosi_in(mosi_line), .sck_in(sck_line),
        .ss_n_in(ss_line), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .ss_n_out(ss_n_out),
        .ss_n_oe_n(ss_n_oe_n), .pin_level(pin_level), .module_enable_bit(men), .master_select_bit(msel),
        .transmit_empty_flag(txe), .receive_full_flag(rxf), .overrun_flag(ovr), .mode_fault_flag(mfl),
        .rx_data_reg(rxd), .wake_req(wake));
    srp_far_dev far (.as_slave(as_slave), .ld(ld), .sck_line(sck_line), .mosi_line(mosi_line),
        .miso_line(miso_line), .p_miso(p_miso), .p_mosi(p_mosi), .p_sck(p_sck), .p_ss_n(p_ss_n),
        .rx_got(rx_got), .m_rx(m_rx));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Hang guard and open-drain watch: data-out may only ever pull low
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (as_slave && wo && !mosi_oe_n && mosi_out !== 1'h0) wo_bad <= 1'h1;
        if (cycles == 8000) begin
            failures++;
            wrap_up;
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // One-cycle strobe: 0 status read, 1 data read, 2 data write
    task automatic acc(input int k, input logic [7:0] b);
        wdata = b;
        {status_rd, data_rd, data_wr} = {k == 0, k == 1, k == 2};
        cyc(1);
        {status_rd, data_rd, data_wr} = 3'h0;
        cyc(1);
    endtask : acc
    task automatic ctrl(input logic e, input logic m, input logic w, input logic f);
        {en, ms, wo, mf} = {e, m, w, f};
        ctrl_wr = 1'h1;
        cyc(1);
        ctrl_wr = 1'h0;
        cyc(1);
    endtask : ctrl
    // Bounded poll: 0 receive full, 1 overrun, 2 enable dropped
    task automatic wait_on(input int k);
        for (int i = 0; i < 400; i++) begin
            cyc(1);
            if ((k == 0 && rxf === 1'h1) || (k == 1 && ovr === 1'h1) || (k == 2 && men === 1'h0)) return;
        end
        chk1(1'h0, 1'h1);
    endtask : wait_on
    task automatic pins_gpio;
        chk8({4'h0, ss_n_oe_n, sck_oe_n, mosi_oe_n, miso_oe_n}, {4'h0, ~ddr});
        chk8({4'h0, ss_n_out, sck_out, mosi_out, miso_out}, {4'h0, gout});
    endtask : pins_gpio
    // Master byte against the far slave, which answers with back
    task automatic mxfer(input logic [7:0] tx, input logic [7:0] back, input int k);
        ld = back;
        as_slave = 1'h1;
        acc(2, tx);
        wait_on(k);
        as_slave = 1'h0;
        chk8(rx_got, tx);
    endtask : mxfer
    task automatic t_reset;
        chk8({5'h00, men, msel, txe}, 8'h03);
        chk8({5'h00, rxf, ovr, mfl}, 8'h00);
        pins_gpio;
        $display("reset test done");
    endtask : t_reset
    task automatic t_master;
        ctrl(1'h1, 1'h1, 1'h0, 1'h0);
        chk8({4'h0, ss_n_oe_n, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h01);
        chk1(ss_n_out, gout[3]);
        mxfer(8'hA5, 8'h3C, 0);
        chk8(rxd, 8'h3C);
        ctrl(1'h1, 1'h1, 1'h1, 1'h0);
        mxfer(8'h81, 8'h18, 1);
        chk8({5'h00, wo_bad, txe, rxf}, 8'h03);
        chk8(rxd, 8'h3C);
        $display("master test done");
    endtask : t_master
    task automatic t_disable;
        ctrl(1'h0, 1'h1, 1'h0, 1'h0);
        chk8({4'h0, txe, rxf, ovr, msel}, 8'h0F);
        pins_gpio;
        acc(2, 8'h11);
        chk1(txe, 1'h1);
        $display("disable test done");
    endtask : t_disable
    task automatic t_halt;
        ctrl(1'h1, 1'h1, 1'h0, 1'h0);
        acc(0, 8'h00);
        halt = 1'h1;
        cyc(2);
        acc(1, 8'h00);
        chk8({6'h00, rxf, ovr}, 8'h03);
        acc(2, 8'h77);
        cyc(12);
        chk8({6'h00, txe, sck_out}, 8'h02);
        halt = 1'h0;
        cyc(2);
        acc(1, 8'h00);
        chk8({6'h00, rxf, ovr}, 8'h00);
        mxfer(8'h24, 8'h42, 0);
        {halt, hce} = 2'h3;
        cyc(2);
        acc(0, 8'h00);
        acc(1, 8'h00);
        chk1(rxf, 1'h0);
        {halt, hce} = 2'h0;
        cyc(2);
        chk1(rxf, 1'h0);
        $display("halt test done");
    endtask : t_halt
    task automatic t_wait;
        rie = 1'h1;
        ctrl(1'h1, 1'h1, 1'h0, 1'h0);
        ld = 8'h5C;
        as_slave = 1'h1;
        acc(2, 8'hE7);
        wait_mode = 1'h1;
        wait_on(0);
        as_slave = 1'h0;
        chk8({6'h00, rxf, wake}, 8'h03);
        chk8(rxd, 8'h5C);
        acc(0, 8'h00);
        acc(1, 8'h00);
        ctrl(1'h0, 1'h1, 1'h0, 1'h0);
        chk8({6'h00, rxf, men}, 8'h03);
        wait_mode = 1'h0;
        rie = 1'h0;
        acc(0, 8'h00);
        acc(1, 8'h00);
        chk8({6'h00, rxf, wake}, 8'h00);
        $display("wait test done");
    endtask : t_wait
    task automatic t_fault;
        ctrl(1'h1, 1'h1, 1'h0, 1'h1);
        chk8({6'h00, ss_n_oe_n, pin_level[3]}, 8'h03);
        ss_low = 1'h1;
        wait_on(2);
        chk8({5'h00, men, mfl, txe}, 8'h03);
        pins_gpio;
        ss_low = 1'h0;
        acc(0, 8'h00);
        ctrl(1'h0, 1'h1, 1'h0, 1'h0);
        chk1(mfl, 1'h0);
        $display("fault test done");
    endtask : t_fault
    task automatic t_slave;
        ctrl(1'h1, 1'h0, 1'h0, 1'h0);
        chk8({4'h0, ss_n_oe_n, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h0F);
        acc(2, 8'hC3);
        fork
            far.send(8'h5A, 8);
            begin
                #100;
                chk8({6'h00, miso_oe_n, pin_level[3]}, 8'h00);
            end
        join
        wait_on(0);
        chk8(rxd, 8'h5A);
        chk8(m_rx, 8'hC3);
        chk1(miso_oe_n, 1'h1);
        acc(0, 8'h00);
        acc(1, 8'h00);
        far.send(8'h0F, 4);
        cyc(10);
        chk1(rxf, 1'h0);
        far.send(8'h96, 8);
        wait_on(0);
        chk8(rxd, 8'h96);
        chk1(mfl, 1'h0);
        ctrl(1'h1, 1'h0, 1'h0, 1'h1);
        far.send(8'h33, 3);
        cyc(4);
        chk1(mfl, 1'h1);
        $display("slave test done");
    endtask : t_slave
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // Inputs settle at time zero, reset holds four cycles, then the scenarios run
    initial begin
        {ctrl_wr, en, clock_phase_select, wo, mf, rie, status_rd, data_rd, data_wr} = 9'h000;
        {wait_mode, halt, hce, as_slave, ss_low, wo_bad} = 6'h00;
        {rst, ce, ms} = 3'h7;
        {ddr, gout} = 8'hFA;
        {wdata, ld} = 16'h0000;
        repeat (4) @(negedge clk);
        rst = 1'h0;
        cyc(2);
        t_reset;
        t_master;
        t_disable;
        t_halt;
        t_wait;
        t_fault;
        t_slave;
        wrap_up;
    end
endmodule : test_spi_reset_and_pin_control
`default_nettype wire
